// [rtl/vcad_regs.svh]
// Address map, field positions and reset values of the backplane address decoder
`ifndef VCAD_REGS_SVH
`define VCAD_REGS_SVH

`define VCAD_LA_DYNAMIC      8'hFF
`define VCAD_LA_RESET        8'hFF
`define VCAD_A16_TOP         2'h3
`define VCAD_OFS_ID          6'h00
`define VCAD_OFS_DTYPE       6'h02
`define VCAD_OFS_STATUS      6'h04
`define VCAD_OFS_OFFSET      6'h06
`define VCAD_OFS_SER_HI      6'h0A
`define VCAD_OFS_SER_LO      6'h0C
`define VCAD_ID_CLASS        2'h3
`define VCAD_ID_SPACE        2'h0
`define VCAD_STATUS_VALUE    16'h400C
`define VCAD_OFFSET_RESET    16'h0000
`define VCAD_BAL_NIBBLE      4'h4
`define VCAD_BAL_RESET       12'h800
`define VCAD_RESP_CYCLES     2

`endif

// [rtl/vcad_pkg.sv]
// Types shared by the backplane address decoder
package vcad_pkg;
	typedef enum logic [1:0] {
		VCAD_IDLE = 2'b01,
		VCAD_RESP = 2'b10
	} vcad_state_t;

	typedef enum logic {
		VCAD_SPACE_A16 = 1'b0,
		VCAD_SPACE_A24 = 1'b1
	} vcad_space_t;
endpackage

// [rtl/vcad_bal_if.sv]
// Carrier between the decoder and its bank of bridge balance codes
interface vcad_bal_if #(
	parameter int CH = 8,
	parameter int W  = 12
);
	logic                      wr;
	logic [$clog2(CH)-1:0]     idx;
	logic [W-1:0]              wdata;
	logic [W-1:0]              rdata;
	logic [CH*W-1:0]           codes;

	modport ctrl (output wr, output idx, output wdata, input rdata, input codes);
	modport bank (input wr, input idx, input wdata, output rdata, output codes);
endinterface

// [rtl/vcad_bal_bank.sv]
// Per-channel balance code storage with registered read port
`include "vcad_regs.svh"

module vcad_bal_bank #(
	parameter int CH = 8,
	parameter int W  = 12
) (
	input  wire logic clk,
	input  wire logic srst,
	vcad_bal_if.bank  bal
);
	logic [W-1:0] mem [CH];

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < CH; i++) begin
				mem[i] <= `VCAD_BAL_RESET;
			end
		end else if (bal.wr) begin
			mem[bal.idx] <= bal.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bal.rdata <= '0;
		end else begin
			bal.rdata <= mem[bal.idx];
		end
	end

	always_comb begin
		for (int i = 0; i < CH; i++) begin
			bal.codes[i*W +: W] = mem[i];
		end
	end
endmodule

// [rtl/vcad_decoder.sv]
// Backplane slave address decoder: logical address, A16 config block, A24 window, balance codes
`include "vcad_regs.svh"

module vcad_decoder #(
	parameter int          CH        = 8,
	parameter int          BAL_W     = 12,
	parameter logic [11:0] MAKER_ID  = 12'hABC,   // Arbitrary value
	parameter logic [11:0] MODEL_ID  = 12'h123,   // Arbitrary value
	parameter logic [3:0]  MEM_REQ   = 4'hC,      // 64 kbytes in A24
	parameter logic [31:0] SERIAL    = 32'h0000_0001  // Arbitrary value
) (
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic [7:0]             la_switch,
	input  wire logic                   acc_req,
	input  wire logic                   acc_space,
	input  wire logic [23:0]            acc_addr,
	input  wire logic                   acc_wr,
	input  wire logic                   acc_wide,
	input  wire logic [15:0]            acc_wdata,
	output logic                        acc_ack,
	output logic                        acc_err,
	output logic [15:0]                 acc_rdata,
	output logic [7:0]                  la_out,
	output logic                        la_dynamic,
	output logic                        op_req,
	output logic                        op_wr,
	output logic [15:0]                 op_addr,
	output logic [15:0]                 op_wdata,
	input  wire logic [15:0]            op_rdata,
	output logic [CH*BAL_W-1:0]         bal_code
);
	localparam int IDX_W = $clog2(CH);

	vcad_pkg::vcad_state_t state;
	logic [7:0]            la_reg;
	logic [15:0]           offset;
	logic                  dyn;
	logic [7:0]            la_eff;
	logic                  hit16;
	logic                  hit24;
	logic                  bal_sel;
	logic                  take;
	logic                  cap_hit;
	logic                  cap_wide;
	logic                  cap_space;
	logic                  cap_bal;
	logic [5:0]            cap_ofs;
	logic [3:0]            chan;

	vcad_bal_if #(.CH(CH), .W(BAL_W)) bal ();

	vcad_bal_bank #(.CH(CH), .W(BAL_W)) u_bank (
		.clk  (clk),
		.srst (srst),
		.bal  (bal)
	);

	assign dyn    = (la_switch == `VCAD_LA_DYNAMIC);
	assign la_eff = dyn ? la_reg : la_switch;
	assign take   = (state == vcad_pkg::VCAD_IDLE) && acc_req;
	assign hit16  = (acc_space == vcad_pkg::VCAD_SPACE_A16) && (acc_addr[15:14] == `VCAD_A16_TOP)
	                && (acc_addr[13:6] == la_eff);
	// Only the CH balance-code words in the first 256 bytes are decoded here; the rest of the 64k window goes out on the op_ port
	assign hit24  = (acc_space == vcad_pkg::VCAD_SPACE_A24)
	                && (acc_addr[23:16] == offset[15:8]);
	assign chan   = acc_addr[7:4];
	assign bal_sel = hit24 && (acc_addr[15:8] == 8'h00) && (acc_addr[3:0] == `VCAD_BAL_NIBBLE)
	                 && (chan >= 4'h1) && (chan <= 4'(CH));

	// Requests arriving while an answer is pending are ignored, not queued
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= vcad_pkg::VCAD_IDLE;
		end else begin
			case (state)
				vcad_pkg::VCAD_IDLE: begin
					if (acc_req) begin
						state <= vcad_pkg::VCAD_RESP;
					end
				end
				vcad_pkg::VCAD_RESP: begin
					state <= vcad_pkg::VCAD_IDLE;
				end
				default: begin
					state <= vcad_pkg::VCAD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cap_hit   <= 1'b0;
			cap_wide  <= 1'b0;
			cap_space <= 1'b0;
			cap_bal   <= 1'b0;
			cap_ofs   <= 6'h00;
		end else if (take) begin
			cap_hit   <= hit16 || hit24;
			cap_wide  <= acc_wide;
			cap_space <= acc_space;
			cap_bal   <= bal_sel;
			cap_ofs   <= acc_addr[5:0];
		end
	end

	// Writes land at the edge that takes the request; wide writes change nothing
	always_ff @(posedge clk) begin
		if (srst) begin
			la_reg <= `VCAD_LA_RESET;
			offset <= `VCAD_OFFSET_RESET;
		end else if (take && hit16 && acc_wr && !acc_wide) begin
			if (acc_addr[5:0] == `VCAD_OFS_ID && dyn) begin
				la_reg <= acc_wdata[7:0];
			end
			if (acc_addr[5:0] == `VCAD_OFS_OFFSET) begin
				offset <= acc_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			la_out     <= `VCAD_LA_RESET;
			la_dynamic <= 1'b0;
		end else begin
			la_out     <= la_eff;
			la_dynamic <= dyn;
		end
	end

	always_comb begin
		bal.wr    = take && bal_sel && acc_wr && !acc_wide;
		bal.idx   = IDX_W'(chan - 4'h1);
		bal.wdata = acc_wdata[BAL_W-1:0];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bal_code <= {CH{`VCAD_BAL_RESET}};
		end else begin
			bal_code <= bal.codes;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			op_req   <= 1'b0;
			op_wr    <= 1'b0;
			op_addr  <= 16'h0000;
			op_wdata <= 16'h0000;
		end else begin
			op_req <= take && hit24 && !bal_sel && !acc_wide;
			if (take) begin
				op_wr    <= acc_wr;
				op_addr  <= acc_addr[15:0];
				op_wdata <= acc_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			acc_ack   <= 1'b0;
			acc_err   <= 1'b0;
			acc_rdata <= 16'h0000;
		end else begin
			acc_ack   <= (state == vcad_pkg::VCAD_RESP) && cap_hit && !cap_wide;
			acc_err   <= (state == vcad_pkg::VCAD_RESP) && cap_hit && cap_wide;
			acc_rdata <= 16'h0000;
			if (state == vcad_pkg::VCAD_RESP && cap_hit && !cap_wide) begin
				if (cap_space == vcad_pkg::VCAD_SPACE_A24) begin
					acc_rdata <= cap_bal ? 16'(bal.rdata) : op_rdata;
				end else begin
					case (cap_ofs)
						`VCAD_OFS_ID:     acc_rdata <= {`VCAD_ID_CLASS, `VCAD_ID_SPACE, MAKER_ID};
						`VCAD_OFS_DTYPE:  acc_rdata <= {MEM_REQ, MODEL_ID};
						`VCAD_OFS_STATUS: acc_rdata <= `VCAD_STATUS_VALUE;
						`VCAD_OFS_OFFSET: acc_rdata <= offset;
						`VCAD_OFS_SER_HI: acc_rdata <= SERIAL[31:16];
						`VCAD_OFS_SER_LO: acc_rdata <= SERIAL[15:0];
						default:          acc_rdata <= 16'h0000;
					endcase
				end
			end
		end
	end

	sequence s_take_hit16;
		take && hit16 && !acc_wide;
	endsequence

	sequence s_answer;
		##2 acc_ack && !acc_err;
	endsequence

	a_hit_answered: assert property (@(posedge clk) disable iff (srst)
		s_take_hit16 |-> s_answer) else $error("Addressed A16 access not answered in two cycles");
	a_wide_refused: assert property (@(posedge clk) disable iff (srst)
		take && (hit16 || hit24) && acc_wide |-> ##2 acc_err && !acc_ack) else $error("Wide transfer not refused");
	a_miss_silent: assert property (@(posedge clk) disable iff (srst)
		take && !hit16 && !hit24 |-> ##1 !op_req ##1 !acc_ack && !acc_err) else $error("Unaddressed access answered");
	a_static_addr: assert property (@(posedge clk) disable iff (srst)
		la_switch != `VCAD_LA_DYNAMIC && $stable(la_switch) |=> la_out == $past(la_switch) && !la_dynamic)
		else $error("Static address not taken from switch");
	a_dyn_addr: assert property (@(posedge clk) disable iff (srst)
		s_take_hit16 ##0 (acc_wr && dyn && acc_addr[5:0] == `VCAD_OFS_ID) ##1 dyn[*1] |=>
		la_out == $past(acc_wdata[7:0], 2)) else $error("Dynamic address write not applied");
	a_a24_window: assert property (@(posedge clk) disable iff (srst)
		op_req |-> $past(acc_addr[23:16]) == offset[15:8] && $past(acc_space)) else $error("A24 access outside window");
	a_bal_write: assert property (@(posedge clk) disable iff (srst)
		bal.wr |-> ##2 bal_code[$past(bal.idx, 2)*BAL_W +: BAL_W] == $past(acc_wdata[BAL_W-1:0], 2))
		else $error("Balance code not stored");
	a_id_read: assert property (@(posedge clk) disable iff (srst)
		s_take_hit16 ##0 (!acc_wr && acc_addr[5:0] == `VCAD_OFS_DTYPE) |-> ##2 acc_rdata == {MEM_REQ, MODEL_ID})
		else $error("Device type read wrong");
endmodule

// [test/vcad_op_model.sv]
// Behavioural model of the user logic behind the operational window
module vcad_op_model (
	input  wire logic        clk,
	input  wire logic        op_req,
	input  wire logic        op_wr,
	input  wire logic [15:0] op_addr,
	input  wire logic [15:0] op_wdata,
	output logic      [15:0] op_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:255];
	logic [15:0] junk = 16'h5A5A;
	// Known contents so that reads before any write can still be checked
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'hC000 | 16'(i);
		end
	end
	always @(posedge clk) begin
		junk <= ~junk;
		if (op_req && op_wr) begin
			mem[op_addr[8:1]] <= op_wdata;
		end
	end
	// Idle data lines toggle, so a late sample can never match a stored word
	assign op_rdata = op_req ? mem[op_addr[8:1]] : junk;
endmodule

// [test/vxi_config_address_decoder_test.sv]
// Self-checking bench for the backplane address decoder
module vxi_config_address_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0;
	logic        srst = 1;
	logic [7:0]  la_switch = 8'h5A;
	logic        acc_req = 0;
	logic        acc_space = 0;
	logic [23:0] acc_addr = 24'h0;
	logic        acc_wr = 0;
	logic        acc_wide = 0;
	logic [15:0] acc_wdata = 16'h0;
	logic        acc_ack, acc_err, la_dynamic, op_req, op_wr;
	logic [15:0] acc_rdata, op_addr, op_wdata, op_rdata;
	logic [7:0]  la_out;
	logic [95:0] bal_code;
	logic        ak, er, oq;
	logic [15:0] rd;
	int          err_total = 0;
	int          n_compared = 0;

	vcad_decoder dut (.clk, .srst, .la_switch, .acc_req, .acc_space, .acc_addr, .acc_wr, .acc_wide,
		.acc_wdata, .acc_ack, .acc_err, .acc_rdata, .la_out, .la_dynamic, .op_req, .op_wr, .op_addr,
		.op_wdata, .op_rdata, .bal_code);
	vcad_op_model user (.clk, .op_req, .op_wr, .op_addr, .op_wdata, .op_rdata);

	always #5 clk = ~clk;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results;
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic logic [23:0] a16(input logic [7:0] la, input logic [5:0] ofs);
		return {8'h00, 2'h3, la, ofs};
	endfunction

	// Request dropped in the busy cycle; answer sampled in the second cycle after the take
	task automatic acc(input logic sp, input logic [23:0] a, input logic wr, input logic wide,
		input logic [15:0] wd);
		@(negedge clk);
		acc_req = 1;
		acc_space = sp;
		acc_addr = a;
		acc_wr = wr;
		acc_wide = wide;
		acc_wdata = wd;
		@(negedge clk);
		acc_req = 0;
		oq = op_req;
		@(negedge clk);
		ak = acc_ack;
		er = acc_err;
		rd = acc_rdata;
	endtask

	task automatic rd_chk(input logic sp, input logic [23:0] a, input logic [15:0] exp);
		acc(sp, a, 0, 0, 16'h0000);
		chk(16'(ak), 16'h0001);
		chk(rd, exp);
	endtask

	task automatic t_static;
		logic [5:0]  ofs [6] = '{6'h00, 6'h02, 6'h04, 6'h0A, 6'h0C, 6'h3E};
		logic [15:0] exp [6] = '{16'hCABC, 16'hC123, 16'h400C, 16'h0000, 16'h0001, 16'h0000};
		chk({8'h00, la_out}, 16'h005A);
		chk(16'(la_dynamic), 16'h0000);
		for (int i = 0; i < 6; i++) begin
			rd_chk(0, a16(8'h5A, ofs[i]), exp[i]);
		end
		acc(0, a16(8'h5A, 6'h04), 1, 0, 16'hFFFF);
		rd_chk(0, a16(8'h5A, 6'h04), 16'h400C);
		acc(0, a16(8'h5A, 6'h00), 1, 0, 16'h0033);
		chk({8'h00, la_out}, 16'h005A);
		acc(0, a16(8'h5B, 6'h00), 0, 0, 16'h0000);
		chk(16'(ak), 16'h0000);
		acc(0, {8'h00, 2'b10, 8'h5A, 6'h00}, 0, 0, 16'h0000);
		chk(16'(ak), 16'h0000);
	endtask

	task automatic t_a24;
		acc(0, a16(8'h5A, 6'h06), 1, 0, 16'h3400);
		rd_chk(0, a16(8'h5A, 6'h06), 16'h3400);
		acc(1, 24'h340200, 1, 0, 16'h1234);
		chk({op_wr, oq, ak}, 3'b111);
		chk(op_addr, 16'h0200);
		chk(op_wdata, 16'h1234);
		rd_chk(1, 24'h340200, 16'h1234);
		chk(16'(oq), 16'h0001);
		rd_chk(1, 24'h34FFFE, 16'hC0FF);
		acc(1, 24'h350200, 0, 0, 16'h0000);
		chk({oq, ak}, 2'b00);
		// Wide transfers are refused and must leave the user side untouched
		acc(0, a16(8'h5A, 6'h00), 0, 1, 16'h0000);
		chk({er, ak}, 2'b10);
		acc(1, 24'h340200, 1, 1, 16'hDEAD);
		chk({er, oq, ak}, 3'b100);
		rd_chk(1, 24'h340200, 16'h1234);
	endtask

	task automatic t_bal;
		for (int n = 1; n <= 8; n++) begin
			acc(1, {8'h34, 8'h00, 4'(n), 4'h4}, 1, 0, 16'hF000 | 16'(n * 12'h101));
			chk(16'(bal_code[(n - 1) * 12 +: 12]), 16'(n * 12'h101));
			rd_chk(1, {8'h34, 8'h00, 4'(n), 4'h4}, 16'(n * 12'h101));
		end
	endtask

	task automatic t_dynamic;
		la_switch = 8'hFF;
		repeat (3) @(negedge clk);
		chk({7'h00, la_dynamic, la_out}, 16'h01FF);
		acc(0, a16(8'hFF, 6'h00), 1, 0, 16'h00FE);
		repeat (2) @(negedge clk);
		chk({8'h00, la_out}, 16'h00FE);
		rd_chk(0, a16(8'hFE, 6'h00), 16'hCABC);
		acc(0, a16(8'hFF, 6'h00), 0, 0, 16'h0000);
		chk(16'(ak), 16'h0000);
		la_switch = 8'h5A;
		repeat (3) @(negedge clk);
		chk({7'h00, la_dynamic, la_out}, 16'h005A);
	endtask

	// Mid-run reset must drop the offset and the channel 1 balance code back to their reset values
	task automatic t_reset;
		srst = 1;
		repeat (2) @(negedge clk);
		chk({op_req, acc_ack, acc_err}, 16'h0000);
		chk(16'(bal_code[11:0]), 16'h0800);
		chk({8'h00, la_out}, 16'h00FF);
		srst = 0;
		repeat (3) @(negedge clk);
		chk({8'h00, la_out}, 16'h005A);
		rd_chk(0, a16(8'h5A, 6'h06), 16'h0000);
		rd_chk(1, {8'h00, 8'h00, 4'h1, 4'h4}, 16'h0800);
	endtask

	initial begin
		repeat (19) @(negedge clk);
		for (int n = 0; n < 8; n++) begin
			chk(16'(bal_code[n * 12 +: 12]), 16'h0800);
		end
		chk({8'h00, la_out}, 16'h00FF);
		@(negedge clk);
		srst = 0;
		repeat (3) @(negedge clk);
		t_static();
		t_a24();
		t_bal();
		t_dynamic();
		t_reset();
		results();
	end

	// A hang is counted as a mismatch and closes the run
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end
endmodule
